// ### verilog/dsp_power_pkg.sv
// constants, register layouts and carriers for the dsp power-on controller
// assumes one 10 MHz clock and apb on both the software and the device side
package dsp_power_pkg;

   // ======================================================================
   // bus shapes
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int SLV_ADDR_W = 12;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic [DATA_W-1:0] wdata;
   } apb_req_s;

   // ======================================================================
   // device register map, base plus word offsets
   localparam logic [ADDR_W-1:0] DEV_BASE = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] TRANSITION_COMMAND_OFF = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] TRANSITION_STATUS_OFF = 32'h0000_0004;
   localparam logic [ADDR_W-1:0] EXT_POWER_PENDING_OFF = 32'h0000_0008;
   localparam logic [ADDR_W-1:0] DSP_DOMAIN_CONTROL_OFF = 32'h0000_000c;
   localparam logic [ADDR_W-1:0] DSP_MODULE_CONTROL_OFF = 32'h0000_0010;
   localparam logic [ADDR_W-1:0] RAIL_SHORT_SWITCH_OFF = 32'h0000_0014;

   // device field positions and values
   localparam int TRANSITION_TRIGGER_BIT = 1;
   localparam int TRANSITION_ACTIVE_BIT = 1;
   localparam int EXT_POWER_PENDING_BIT = 1;
   localparam int DOMAIN_TARGET_BIT = 0;
   localparam int EXT_POWER_GOOD_BIT = 8;
   localparam int DSP_RAIL_SHORT_BIT = 0;
   localparam int MODULE_TARGET_LSB = 0;
   localparam int MODULE_TARGET_W = 3;
   localparam logic [MODULE_TARGET_W-1:0] SW_RESET_DISABLED_STATE = 3'h0;
   localparam logic [MODULE_TARGET_W-1:0] MODULE_ENABLE_STATE = 3'h3;

   // ======================================================================
   // controller registers seen by software
   localparam logic [SLV_ADDR_W-1:0] CTRL_OFF = 12'h000;
   localparam logic [SLV_ADDR_W-1:0] STATUS_OFF = 12'h004;
   localparam logic [SLV_ADDR_W-1:0] IRQ_STATUS_OFF = 12'h008;
   localparam logic [SLV_ADDR_W-1:0] IRQ_MASK_OFF = 12'h00c;

   localparam int CTRL_START_BIT = 0;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_DONE_BIT = 1;
   localparam int STATUS_ERROR_BIT = 2;
   localparam int STATUS_EPC_BIT = 3;
   localparam int STATUS_STEP_LSB = 8;
   localparam int STEP_W = 4;

   localparam int IRQ_W = 3;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_EPC_BIT = 1;
   localparam int IRQ_ERROR_BIT = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

endpackage : dsp_power_pkg

// ### verilog/apb_master_port.sv
// apb master issuing one transfer per start pulse
// assumes the caller waits for done before the next start
`timescale 1ns/10ps
module apb_master_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire dsp_power_pkg::apb_req_s req,
   output logic done,
   output logic err,
   output logic [dsp_power_pkg::DATA_W-1:0] rdata,
   output logic m_psel,
   output logic m_penable,
   output logic [dsp_power_pkg::ADDR_W-1:0] m_paddr,
   output logic m_pwrite,
   output logic [dsp_power_pkg::DATA_W-1:0] m_pwdata,
   input wire logic [dsp_power_pkg::DATA_W-1:0] m_prdata,
   input wire logic m_pready,
   input wire logic m_pslverr
);

   // ======================================================================
   // phase control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_psel <= 1'b0;
         m_penable <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!m_psel && start) begin
            m_psel <= 1'b1;
         end else if (m_psel && !m_penable) begin
            m_penable <= 1'b1;
         end else if (m_psel && m_penable && m_pready) begin
            m_psel <= 1'b0;
            m_penable <= 1'b0;
            done <= 1'b1;
         end
      end
   end

   // ======================================================================
   // request hold and answer capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_paddr <= '0;
         m_pwrite <= 1'b0;
         m_pwdata <= '0;
         rdata <= '0;
         err <= 1'b0;
      end else begin
         if (!m_psel && start) begin
            m_paddr <= req.addr;
            m_pwrite <= req.write;
            m_pwdata <= req.wdata;
         end
         if (m_psel && m_penable && m_pready) begin
            rdata <= m_prdata;
            err <= m_pslverr;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   hold_request_a: assert property (m_psel && !(m_penable && m_pready) |=>
      m_psel && $stable(m_paddr) && $stable(m_pwrite) && $stable(m_pwdata))
      else $error("apb request changed before completion");
   enable_order_a: assert property ($rose(m_penable) |-> $past(m_psel) && !$past(m_penable))
      else $error("penable rose without a setup cycle");

endmodule : apb_master_port

// ### verilog/dsp_power_on_ctrl.sv
// host-side controller that runs the dsp domain power-on sequence
// software orders it over apb; it drives the sequencer registers over a second apb port
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module dsp_power_on_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dsp_power_pkg::SLV_ADDR_W-1:0] paddr,
   input wire logic [dsp_power_pkg::DATA_W-1:0] pwdata,
   output logic [dsp_power_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic m_psel,
   output logic m_penable,
   output logic [dsp_power_pkg::ADDR_W-1:0] m_paddr,
   output logic m_pwrite,
   output logic [dsp_power_pkg::DATA_W-1:0] m_pwdata,
   input wire logic [dsp_power_pkg::DATA_W-1:0] m_prdata,
   input wire logic m_pready,
   input wire logic m_pslverr
);

   // ======================================================================
   // sequence steps
   typedef enum logic [dsp_power_pkg::STEP_W-1:0] {
      S_IDLE,
      S_POLL_PRE,
      S_DOM_NEXT,
      S_MOD_OFF,
      S_TRIG_ON,
      S_WAIT_EPC,
      S_RAIL_SHORT,
      S_PWR_GOOD,
      S_POLL_MID,
      S_MOD_EN,
      S_TRIG_EN,
      S_POLL_END
   } step_e;

   step_e state_reg;
   logic pending_reg;
   logic done_reg;
   logic error_reg;
   logic epc_seen_reg;
   logic [dsp_power_pkg::IRQ_W-1:0] irq_status_reg;
   logic [dsp_power_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [dsp_power_pkg::IRQ_W-1:0] irq_event;
   logic mst_start;
   logic mst_done;
   logic mst_err;
   logic [dsp_power_pkg::DATA_W-1:0] mst_rdata;
   dsp_power_pkg::apb_req_s mst_req;
   logic wr_take;
   logic go_cmd;
   logic ok_done;

   // ======================================================================
   // helpers
   function automatic logic [dsp_power_pkg::ADDR_W-1:0] dev_addr(input logic [dsp_power_pkg::ADDR_W-1:0] off);
      dev_addr = dsp_power_pkg::DEV_BASE + off;
   endfunction : dev_addr

   function automatic logic [dsp_power_pkg::DATA_W-1:0] one_bit(input int pos);
      one_bit = '0;
      one_bit[pos] = 1'b1;
   endfunction : one_bit

   function automatic logic [dsp_power_pkg::DATA_W-1:0] module_target(
      input logic [dsp_power_pkg::MODULE_TARGET_W-1:0] code);
      module_target = '0;
      module_target[dsp_power_pkg::MODULE_TARGET_LSB +: dsp_power_pkg::MODULE_TARGET_W] = code;
   endfunction : module_target

   function automatic logic is_reg(input logic [dsp_power_pkg::SLV_ADDR_W-1:0] a,
                                   input logic [dsp_power_pkg::SLV_ADDR_W-1:0] off);
      is_reg = (a == off);
   endfunction : is_reg

   function automatic logic in_bus_step(input step_e s);
      in_bus_step = (s != S_IDLE);
   endfunction : in_bus_step

   // ======================================================================
   // device access for each step
   always_comb begin
      mst_req.addr = dev_addr(dsp_power_pkg::TRANSITION_STATUS_OFF);
      mst_req.write = 1'b0;
      mst_req.wdata = '0;
      unique case (state_reg)
         S_IDLE, S_POLL_PRE, S_POLL_MID, S_POLL_END: begin
            mst_req.addr = dev_addr(dsp_power_pkg::TRANSITION_STATUS_OFF);
         end
         S_DOM_NEXT: begin
            mst_req.addr = dev_addr(dsp_power_pkg::DSP_DOMAIN_CONTROL_OFF);
            mst_req.write = 1'b1;
            mst_req.wdata = one_bit(dsp_power_pkg::DOMAIN_TARGET_BIT);
         end
         S_MOD_OFF: begin
            mst_req.addr = dev_addr(dsp_power_pkg::DSP_MODULE_CONTROL_OFF);
            mst_req.write = 1'b1;
            mst_req.wdata = module_target(dsp_power_pkg::SW_RESET_DISABLED_STATE);
         end
         S_TRIG_ON, S_TRIG_EN: begin
            mst_req.addr = dev_addr(dsp_power_pkg::TRANSITION_COMMAND_OFF);
            mst_req.write = 1'b1;
            mst_req.wdata = one_bit(dsp_power_pkg::TRANSITION_TRIGGER_BIT);
         end
         S_WAIT_EPC: begin
            mst_req.addr = dev_addr(dsp_power_pkg::EXT_POWER_PENDING_OFF);
         end
         S_RAIL_SHORT: begin
            mst_req.addr = dev_addr(dsp_power_pkg::RAIL_SHORT_SWITCH_OFF);
            mst_req.write = 1'b1;
            mst_req.wdata = one_bit(dsp_power_pkg::DSP_RAIL_SHORT_BIT);
         end
         S_PWR_GOOD: begin
            mst_req.addr = dev_addr(dsp_power_pkg::DSP_DOMAIN_CONTROL_OFF);
            mst_req.write = 1'b1;
            mst_req.wdata = one_bit(dsp_power_pkg::DOMAIN_TARGET_BIT) |
                            one_bit(dsp_power_pkg::EXT_POWER_GOOD_BIT);
         end
         S_MOD_EN: begin
            mst_req.addr = dev_addr(dsp_power_pkg::DSP_MODULE_CONTROL_OFF);
            mst_req.write = 1'b1;
            mst_req.wdata = module_target(dsp_power_pkg::MODULE_ENABLE_STATE);
         end
      endcase
   end

   assign mst_start = in_bus_step(state_reg) && !pending_reg;
   assign ok_done = mst_done && !mst_err;

   apb_master_port u_master (
      .pclk(pclk),
      .presetn(presetn),
      .start(mst_start),
      .req(mst_req),
      .done(mst_done),
      .err(mst_err),
      .rdata(mst_rdata),
      .m_psel(m_psel),
      .m_penable(m_penable),
      .m_paddr(m_paddr),
      .m_pwrite(m_pwrite),
      .m_pwdata(m_pwdata),
      .m_prdata(m_prdata),
      .m_pready(m_pready),
      .m_pslverr(m_pslverr)
   );

   // ======================================================================
   // software register access
   assign wr_take = psel && penable && pready && pwrite;
   assign go_cmd = wr_take && is_reg(paddr, dsp_power_pkg::CTRL_OFF) && pwdata[dsp_power_pkg::CTRL_START_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(is_reg(paddr, dsp_power_pkg::CTRL_OFF) ||
                    is_reg(paddr, dsp_power_pkg::STATUS_OFF) || is_reg(paddr, dsp_power_pkg::IRQ_STATUS_OFF) ||
                    is_reg(paddr, dsp_power_pkg::IRQ_MASK_OFF));
         prdata <= '0;
         if (psel && !penable && !pwrite) begin
            if (is_reg(paddr, dsp_power_pkg::STATUS_OFF)) begin
               prdata[dsp_power_pkg::STATUS_BUSY_BIT] <= in_bus_step(state_reg);
               prdata[dsp_power_pkg::STATUS_DONE_BIT] <= done_reg;
               prdata[dsp_power_pkg::STATUS_ERROR_BIT] <= error_reg;
               prdata[dsp_power_pkg::STATUS_EPC_BIT] <= epc_seen_reg;
               prdata[dsp_power_pkg::STATUS_STEP_LSB +: dsp_power_pkg::STEP_W] <= state_reg;
            end else if (is_reg(paddr, dsp_power_pkg::IRQ_STATUS_OFF)) begin
               prdata[dsp_power_pkg::IRQ_W-1:0] <= irq_status_reg;
            end else if (is_reg(paddr, dsp_power_pkg::IRQ_MASK_OFF)) begin
               prdata[dsp_power_pkg::IRQ_W-1:0] <= irq_mask_reg;
            end
         end
      end
   end

   // ======================================================================
   // sequence state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_reg <= 1'b0;
      end else if (mst_done) begin
         pending_reg <= 1'b0;
      end else if (mst_start) begin
         pending_reg <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
      end else if (mst_done && mst_err) begin
         state_reg <= S_IDLE;
      end else begin
         unique case (state_reg)
            S_IDLE: if (go_cmd) state_reg <= S_POLL_PRE;
            S_POLL_PRE: begin
               if (ok_done && !mst_rdata[dsp_power_pkg::TRANSITION_ACTIVE_BIT]) state_reg <= S_DOM_NEXT;
            end
            S_DOM_NEXT: if (ok_done) state_reg <= S_MOD_OFF;
            S_MOD_OFF: if (ok_done) state_reg <= S_TRIG_ON;
            S_TRIG_ON: if (ok_done) state_reg <= S_WAIT_EPC;
            S_WAIT_EPC: begin
               if (ok_done && mst_rdata[dsp_power_pkg::EXT_POWER_PENDING_BIT]) state_reg <= S_RAIL_SHORT;
            end
            S_RAIL_SHORT: if (ok_done) state_reg <= S_PWR_GOOD;
            S_PWR_GOOD: if (ok_done) state_reg <= S_POLL_MID;
            S_POLL_MID: begin
               if (ok_done && !mst_rdata[dsp_power_pkg::TRANSITION_ACTIVE_BIT]) state_reg <= S_MOD_EN;
            end
            S_MOD_EN: if (ok_done) state_reg <= S_TRIG_EN;
            S_TRIG_EN: if (ok_done) state_reg <= S_POLL_END;
            S_POLL_END: begin
               if (ok_done && !mst_rdata[dsp_power_pkg::TRANSITION_ACTIVE_BIT]) state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ======================================================================
   // outcome flags and events
   always_comb begin
      irq_event = '0;
      irq_event[dsp_power_pkg::IRQ_DONE_BIT] = (state_reg == S_POLL_END) && ok_done &&
                                                !mst_rdata[dsp_power_pkg::TRANSITION_ACTIVE_BIT];
      irq_event[dsp_power_pkg::IRQ_EPC_BIT] = (state_reg == S_WAIT_EPC) && ok_done &&
                                               mst_rdata[dsp_power_pkg::EXT_POWER_PENDING_BIT];
      irq_event[dsp_power_pkg::IRQ_ERROR_BIT] = mst_done && mst_err;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
         error_reg <= 1'b0;
         epc_seen_reg <= 1'b0;
      end else if (state_reg == S_IDLE && go_cmd) begin
         done_reg <= 1'b0;
         error_reg <= 1'b0;
         epc_seen_reg <= 1'b0;
      end else begin
         if (irq_event[dsp_power_pkg::IRQ_DONE_BIT]) done_reg <= 1'b1;
         if (irq_event[dsp_power_pkg::IRQ_ERROR_BIT]) error_reg <= 1'b1;
         if (irq_event[dsp_power_pkg::IRQ_EPC_BIT]) epc_seen_reg <= 1'b1;
      end
   end

   // ======================================================================
   // interrupt status, mask and output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= '0;
      end else if (wr_take && is_reg(paddr, dsp_power_pkg::IRQ_STATUS_OFF)) begin
         irq_status_reg <= (irq_status_reg & ~pwdata[dsp_power_pkg::IRQ_W-1:0]) | irq_event;
      end else begin
         irq_status_reg <= irq_status_reg | irq_event;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= dsp_power_pkg::IRQ_MASK_RESET;
      end else if (wr_take && is_reg(paddr, dsp_power_pkg::IRQ_MASK_OFF)) begin
         irq_mask_reg <= pwdata[dsp_power_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // ======================================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   start_order_a: assert property (state_reg == S_IDLE && go_cmd |=> state_reg == S_POLL_PRE)
      else $error("start did not begin with the status poll");
   pre_poll_gate_a: assert property (state_reg == S_POLL_PRE && ok_done &&
      mst_rdata[dsp_power_pkg::TRANSITION_ACTIVE_BIT] |=> state_reg == S_POLL_PRE ##1 m_psel)
      else $error("sequence left the pre poll while the sequencer was active");
   domain_target_a: assert property (state_reg == S_DOM_NEXT && m_psel |-> m_pwrite &&
      m_paddr == dev_addr(dsp_power_pkg::DSP_DOMAIN_CONTROL_OFF) &&
      m_pwdata[dsp_power_pkg::DOMAIN_TARGET_BIT])
      else $error("domain target write is wrong");
   module_off_a: assert property (state_reg == S_MOD_OFF && m_psel |-> m_pwrite &&
      m_paddr == dev_addr(dsp_power_pkg::DSP_MODULE_CONTROL_OFF) &&
      m_pwdata[dsp_power_pkg::MODULE_TARGET_W-1:0] == dsp_power_pkg::SW_RESET_DISABLED_STATE)
      else $error("module reset-disabled write is wrong");
   trigger_write_a: assert property ((state_reg == S_TRIG_ON || state_reg == S_TRIG_EN) && m_psel |->
      m_pwrite && m_paddr == dev_addr(dsp_power_pkg::TRANSITION_COMMAND_OFF) &&
      m_pwdata[dsp_power_pkg::TRANSITION_TRIGGER_BIT])
      else $error("trigger write is wrong");
   epc_gate_a: assert property (state_reg == S_RAIL_SHORT |-> (epc_seen_reg && $past(epc_seen_reg)) ||
      $past(state_reg) == S_WAIT_EPC)
      else $error("rail short reached before external power pending");
   rail_short_a: assert property (state_reg == S_RAIL_SHORT && m_psel |-> m_pwrite &&
      m_paddr == dev_addr(dsp_power_pkg::RAIL_SHORT_SWITCH_OFF) &&
      m_pwdata[dsp_power_pkg::DSP_RAIL_SHORT_BIT])
      else $error("rail short write is wrong");
   power_good_a: assert property (state_reg == S_PWR_GOOD && m_psel |-> m_pwrite &&
      m_paddr == dev_addr(dsp_power_pkg::DSP_DOMAIN_CONTROL_OFF) &&
      m_pwdata[dsp_power_pkg::EXT_POWER_GOOD_BIT] && m_pwdata[dsp_power_pkg::DOMAIN_TARGET_BIT])
      else $error("power good write is wrong");
   module_enable_a: assert property (state_reg == S_MOD_EN && m_psel |-> m_pwrite &&
      m_paddr == dev_addr(dsp_power_pkg::DSP_MODULE_CONTROL_OFF) &&
      m_pwdata[dsp_power_pkg::MODULE_TARGET_W-1:0] == dsp_power_pkg::MODULE_ENABLE_STATE)
      else $error("module enable write is wrong");
   end_done_a: assert property ($rose(done_reg) |-> $past(state_reg) == S_POLL_END && state_reg == S_IDLE)
      else $error("done raised outside the final poll");
   mid_poll_a: assert property (state_reg == S_POLL_MID && ok_done &&
      mst_rdata[dsp_power_pkg::TRANSITION_ACTIVE_BIT] |=> state_reg == S_POLL_MID)
      else $error("enable step taken while first transition active");
   irq_level_a: assert property (|(irq_status_reg & irq_mask_reg) |=> irq)
      else $error("unmasked status without interrupt");

   seq_done_c: cover property (state_reg == S_POLL_END ##1 done_reg);
   epc_wait_c: cover property (state_reg == S_WAIT_EPC && ok_done && !mst_rdata[dsp_power_pkg::EXT_POWER_PENDING_BIT]);
   bus_error_c: cover property (mst_done && mst_err);
   irq_raise_c: cover property ($rose(irq));

endmodule : dsp_power_on_ctrl

// ### verification/dev_seq_model.sv
// power sequencer device model answering the controller's apb master
// assumes one clock shared with the controller
`timescale 1ns/10ps
module dev_seq_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] paddr,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slow,
   input wire logic err_inject,
   output logic bad
);
   // ==========
   // register reads
   logic [31:0] dom_reg, mod_reg, rail_reg, rd_reg, last_reg;
   logic active_reg, pend_reg, good_reg;
   logic [3:0] t_reg, w_reg;
   assign pready = psel & penable & (w_reg >= (slow ? 4'h2 : 4'h0));
   assign pslverr = pready & err_inject;
   assign prdata = pready ? rd_reg : ~last_reg;
   always_comb begin
      case (paddr)
         32'h4: rd_reg = {30'h0, active_reg, 1'b0};
         32'h8: rd_reg = {30'h0, pend_reg, 1'b0};
         32'hc: rd_reg = dom_reg;
         32'h10: rd_reg = mod_reg;
         32'h14: rd_reg = rail_reg;
         default: rd_reg = 32'h0;
      endcase
   end
   // ==========
   // sequencer and order watch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {dom_reg, mod_reg, rail_reg, last_reg} <= '0;
         {pend_reg, good_reg, bad} <= '0;
         active_reg <= 1'b1;
         t_reg <= 4'hf;
         w_reg <= 4'h0;
      end else begin
         w_reg <= (psel & penable & !pready) ? w_reg + 4'h1 : 4'h0;
         if (pready) last_reg <= rd_reg;
         if (t_reg != 4'h0) t_reg <= t_reg - 4'h1;
         if (t_reg == 4'h1 && dom_reg[0] && !good_reg) pend_reg <= 1'b1;
         else if (t_reg == 4'h1) active_reg <= 1'b0;
         if (pready & pwrite & !err_inject) begin
            case (paddr)
               32'h0: if (pwdata[1]) begin
                  bad <= bad | active_reg | !dom_reg[0] | (mod_reg[2:0] != (good_reg ? 3'h3 : 3'h0));
                  active_reg <= 1'b1;
                  t_reg <= 4'h5;
               end
               32'hc: begin
                  dom_reg <= pwdata;
                  if (pwdata[8]) begin
                     bad <= bad | !pend_reg | !rail_reg[0];
                     good_reg <= 1'b1;
                     t_reg <= 4'h5;
                  end
               end
               32'h10: begin
                  mod_reg <= pwdata;
                  bad <= bad | active_reg;
               end
               32'h14: begin
                  rail_reg <= pwdata;
                  bad <= bad | !pend_reg;
               end
               default: bad <= 1'b1;
            endcase
         end
      end
   end
endmodule : dev_seq_model

// ### verification/tb.sv
// self-checking bench for the dsp power-on controller
// assumes the device model in dev_seq_model.sv
`timescale 1ns/10ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, slow, err_inject, bad, er;
   logic pready, pslverr, irq, m_psel, m_penable, m_pwrite, m_pready, m_pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, m_prdata, m_paddr, m_pwdata, rd;
   int fail_count, n_tests;
   dsp_power_on_ctrl i_dsp_power_on_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq, .m_psel, .m_penable, .m_paddr, .m_pwrite, .m_pwdata, .m_prdata, .m_pready, .m_pslverr);
   dev_seq_model i_dev_seq_model (.pclk, .presetn, .psel(m_psel), .penable(m_penable), .paddr(m_paddr),
      .pwrite(m_pwrite), .pwdata(m_pwdata), .prdata(m_prdata), .pready(m_pready), .pslverr(m_pslverr),
      .slow, .err_inject, .bad);
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ==========
   // shared tasks
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         fail_count++;
         close_out;
      end
      @(posedge pclk);
   endtask : apb
   task automatic do_reset(input logic s, input logic e);
      presetn <= 1'b0;
      slow <= s;
      err_inject <= e;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : do_reset
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, 12'h004, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 500);
      if (n >= 500) begin
         fail_count++;
         close_out;
      end
   endtask : wait_idle
   // ==========
   // scenarios
   task automatic t_reset;
      do_reset(1'b0, 1'b0);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({rd[30:0], er}, 32'h1);
   endtask : t_reset
   task automatic t_run(input logic s, input logic [31:0] mask);
      do_reset(s, 1'b0);
      apb(1'b1, 12'h00c, mask);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[0], 1'b1);
      wait_idle;
      chk(rd, 32'h0000_000a);
      chk(bad, 1'b0);
      chk(i_dev_seq_model.dom_reg, 32'h0000_0101);
      chk(i_dev_seq_model.mod_reg, 32'h3);
      chk(i_dev_seq_model.rail_reg, 32'h1);
      chk(i_dev_seq_model.pend_reg, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h3);
      chk(irq, mask[1:0] != 2'h0);
      apb(1'b1, 12'h008, 32'h7);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
      chk(irq, 1'b0);
   endtask : t_run
   task automatic t_err;
      do_reset(1'b0, 1'b1);
      apb(1'b1, 12'h00c, 32'h4);
      apb(1'b1, 12'h000, 32'h1);
      wait_idle;
      chk(rd, 32'h4);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h4);
      chk(irq, 1'b1);
   endtask : t_err
   initial begin
      {presetn, psel, penable, pwrite, slow, err_inject} = '0;
      paddr = 12'h0;
      pwdata = 32'h0;
      fail_count = 0;
      n_tests = 0;
      t_reset;
      t_run(1'b0, 32'h7);
      t_run(1'b1, 32'h0);
      t_err;
      close_out;
   end
endmodule : tb
